// [inc/chop_cfg_pkg.sv]
package chop_cfg_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CHOP_CONF = 8'h00;
   localparam logic [7:0] OFS_CHOP_AMPL = 8'h04;
   localparam logic [7:0] OFS_CHOP_STAT = 8'h08;
   localparam logic [7:0] OFS_CHOP_MEAS = 8'h0c;
   // Field positions in the configuration word
   localparam int POS_LIM = 0;
   localparam int POS_AUTOSCALE = 4;
   localparam int POS_AUTOGRAD = 5;
   localparam int POS_FREQ = 6;
   localparam int POS_REG = 8;
   localparam int POS_STANDSTILL = 12;
   localparam int POS_BLANK = 14;
   localparam int POS_CHOP_EN = 16;
   localparam int POS_CURMODE = 17;
   localparam int POS_STANDSTILL_IN = 18;
   // Field positions in the amplitude word
   localparam int POS_OFS = 0;
   localparam int POS_GRAD = 8;
   // Reset values
   localparam logic [3:0] RST_LIM = 4'hc;
   localparam logic [3:0] RST_REG = 4'h1;
   localparam logic [7:0] RST_OFS = 8'h00;
   localparam logic [7:0] RST_GRAD = 8'h00;
   // Frequency select: setting 0 gives 2 clocks per 1024, others 2/683, 2/512, 2/410
   localparam logic [9:0] FREQ_DIV0 = 10'h200;
   localparam logic [9:0] FREQ_DIV1 = 10'h156;
   localparam logic [9:0] FREQ_DIV2 = 10'h100;
   localparam logic [9:0] FREQ_DIV3 = 10'h0cd;
   // Blank times in clock cycles for settings 0..3
   localparam logic [5:0] BLANK_0 = 6'h10;
   localparam logic [5:0] BLANK_1 = 6'h18;
   localparam logic [5:0] BLANK_2 = 6'h24;
   localparam logic [5:0] BLANK_3 = 6'h36;
   // Standstill options
   localparam logic [1:0] SS_NORMAL = 2'h0;
   localparam logic [1:0] SS_STANDSTILL_OPTION = 2'h1;
   localparam logic [1:0] SS_SHORT_LS = 2'h2;
   localparam logic [1:0] SS_SHORT_HS = 2'h3;
endpackage : chop_cfg_pkg

// [inc/chop_ctl_if.sv]
`timescale 1ns/1ps
interface chop_ctl_if;
   logic [1:0] freq_sel;
   logic [1:0] blank_sel;
   logic chop_en;
   logic cycle_strobe;
   logic switch_event;
   logic blanking;
   modport gen (input freq_sel, input blank_sel, input chop_en, output cycle_strobe, output switch_event,
      output blanking);
   modport ctl (output freq_sel, output blank_sel, output chop_en, input cycle_strobe, input switch_event,
      input blanking);
endinterface : chop_ctl_if

// [rtl/chop_timer.sv]
`timescale 1ns/1ps
module chop_timer
   import chop_cfg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   chop_ctl_if.gen ctl
);
   logic [9:0] cnt_reg;
   logic [9:0] half_period;
   logic [5:0] blank_reg;
   logic [5:0] blank_len;
   logic edge_now;

   // Half of the effective chopper period per frequency setting
   always_comb begin
      unique case (ctl.freq_sel)
         2'h0: half_period = FREQ_DIV0;
         2'h1: half_period = FREQ_DIV1;
         2'h2: half_period = FREQ_DIV2;
         default: half_period = FREQ_DIV3;
      endcase
      unique case (ctl.blank_sel)
         2'h0: blank_len = BLANK_0;
         2'h1: blank_len = BLANK_1;
         2'h2: blank_len = BLANK_2;
         default: blank_len = BLANK_3;
      endcase
   end

   assign edge_now = ctl.chop_en && (cnt_reg >= half_period - 10'h001);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_reg <= 10'h000;
         ctl.cycle_strobe <= 1'b0;
         ctl.switch_event <= 1'b0;
      end else begin
         cnt_reg <= (edge_now || !ctl.chop_en) ? 10'h000 : cnt_reg + 10'h001;
         ctl.switch_event <= edge_now;
         ctl.cycle_strobe <= edge_now;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         blank_reg <= 6'h00;
         ctl.blanking <= 1'b0;
      end else if (edge_now) begin
         blank_reg <= blank_len;
         ctl.blanking <= 1'b1;
      end else if (blank_reg != 6'h00) begin
         blank_reg <= blank_reg - 6'h01;
         ctl.blanking <= (blank_reg != 6'h01);
      end else begin
         ctl.blanking <= 1'b0;
      end
   end
endmodule : chop_timer

// [rtl/amp_tuner.sv]
`timescale 1ns/1ps
module amp_tuner
   import chop_cfg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic step_i,
   input wire logic autoscale_i,
   input wire logic autograd_i,
   input wire logic freeze_i,
   input wire logic [3:0] gain_i,
   input wire logic [7:0] ofs_i,
   input wire logic [7:0] grad_i,
   input wire logic [7:0] meas_i,
   input wire logic [7:0] target_i,
   output logic [8:0] scale_auto_o,
   output logic [7:0] ofs_auto_o,
   output logic [7:0] grad_auto_o
);
   logic signed [9:0] err;
   logic signed [13:0] corr;
   logic signed [9:0] step_corr;
   logic seeded_reg;

   // Error times gain over 16, gain/16 steps per unit of error per update
   always_comb begin
      err = $signed({2'b00, target_i}) - $signed({2'b00, meas_i});
      corr = err * $signed({1'b0, gain_i});
      step_corr = corr[13:4];
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         scale_auto_o <= 9'h000;
      end else if (!autoscale_i) begin
         scale_auto_o <= 9'h000;
      end else if (step_i && !freeze_i) begin
         scale_auto_o <= scale_auto_o + step_corr[8:0];
      end
   end

   // offset and gradient tuning seeded from user fields
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ofs_auto_o <= 8'h00;
         grad_auto_o <= 8'h00;
         seeded_reg <= 1'b0;
      end else if (!autoscale_i || !seeded_reg) begin
         ofs_auto_o <= ofs_i;
         grad_auto_o <= grad_i;
         seeded_reg <= autoscale_i;
      end else if (step_i && !freeze_i) begin
         if (ofs_i != 8'h00 && err > 0 && ofs_auto_o != 8'hff) ofs_auto_o <= ofs_auto_o + 8'h01;
         else if (ofs_i != 8'h00 && err < 0 && ofs_auto_o != 8'h00) ofs_auto_o <= ofs_auto_o - 8'h01;
         if (!autograd_i) grad_auto_o <= grad_i;
         else if (err > 0 && grad_auto_o != 8'hff) grad_auto_o <= grad_auto_o + 8'h01;
         else if (err < 0 && grad_auto_o != 8'h00) grad_auto_o <= grad_auto_o - 8'h01;
      end
   end
endmodule : amp_tuner

// [rtl/quiet_chopper_cfg.sv]
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
// Function
// - Amplitude limit field is upper nibble of 8-bit limit at chopper switch, reset 12.
// - Auto-scaling bit 0 uses velocity feed-forward, 1 uses current regulator.
// - Auto-gradient bit 0 uses user gradient, 1 tunes gradient automatically when auto-scaling is on.
// - Frequency select sets chopper rate; setting 0 gives 2/1024 clocks.
// - Regulation gain 1..15 gives 1/16 to 15/16 scale steps per unit of error per step.
// - Offset amplitude drives velocity scaling and seeds tuning; zero disables offset tuning.
// - Gradient amplitude drives velocity scaling and seeds gradient tuning.
// - Standstill option selects normal, standstill_option, or low/high-side coil short.
// - Read-only auto scale value, frozen during current-mode chopping.
// - Tuned gradient and offset values readable by software.
// - Comparator blanked for selectable time after each switching event.
module quiet_chopper_cfg
   import chop_cfg_pkg::*;
(
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic CURRENT_MEAS_VALID_I,
   input wire logic [7:0] CURRENT_MEAS_I,
   input wire logic [7:0] VELOCITY_I,
   output logic [7:0] PWM_AMPLITUDE_O,
   output logic STANDSTILL_OPTION_MODE_O,
   output logic LS_SHORT_O,
   output logic HS_SHORT_O,
   output logic CYCLE_STROBE_O,
   output logic BLANKING_O
);
   logic [31:0] conf_reg;
   logic [15:0] ampl_reg;
   logic [7:0] meas_s1_reg;
   logic [7:0] meas_s2_reg;
   logic [7:0] vel_s1_reg;
   logic [7:0] vel_s2_reg;
   logic mv_s1_reg;
   logic mv_s2_reg;
   logic mv_d_reg;
   logic [7:0] target_reg;
   logic prev_curmode_reg;
   logic limit_active_reg;
   logic [3:0] lim;
   logic autoscale;
   logic autograd;
   logic [1:0] standstill;
   logic curmode;
   logic standstill_in;
   logic [8:0] scale_auto;
   logic [7:0] ofs_auto;
   logic [7:0] grad_auto;
   logic [7:0] grad_use;
   logic [15:0] vel_prod;
   logic [9:0] amp_next;
   logic [7:0] amp_sat;
   logic [7:0] limit8;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   chop_ctl_if cif ();

   // Field extraction from the configuration word
   assign lim = conf_reg[POS_LIM +: 4];
   assign autoscale = conf_reg[POS_AUTOSCALE];
   assign autograd = conf_reg[POS_AUTOGRAD];
   assign standstill = conf_reg[POS_STANDSTILL +: 2];
   assign curmode = conf_reg[POS_CURMODE];
   assign standstill_in = conf_reg[POS_STANDSTILL_IN];
   assign cif.freq_sel = conf_reg[POS_FREQ +: 2];
   assign cif.blank_sel = conf_reg[POS_BLANK +: 2];
   assign cif.chop_en = conf_reg[POS_CHOP_EN];

   // Single-cycle APB access, unmapped offsets answer with an error
   assign addr_ok = (PADDR_I == OFS_CHOP_CONF) || (PADDR_I == OFS_CHOP_AMPL) ||
      (PADDR_I == OFS_CHOP_STAT) || (PADDR_I == OFS_CHOP_MEAS);
   assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && addr_ok;
   assign rd_en = PSEL_I && !PWRITE_I;

   // APB answer flops; ready is high in the access phase only
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
      end else begin
         PREADY_O <= PSEL_I && !PENABLE_I;
         PSLVERR_O <= PSEL_I && !PENABLE_I && !addr_ok;
      end
   end

   // Read data captured in the setup cycle so it comes from a flop
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         PRDATA_O <= 32'h0000_0000;
      end else if (rd_en && !PENABLE_I) begin
         unique case (PADDR_I)
            OFS_CHOP_CONF: PRDATA_O <= conf_reg;
            OFS_CHOP_AMPL: PRDATA_O <= {16'h0000, ampl_reg};
            OFS_CHOP_STAT: PRDATA_O <= {7'h00, scale_auto, grad_auto, ofs_auto};
            OFS_CHOP_MEAS: PRDATA_O <= {16'h0000, limit_active_reg, 7'h00, PWM_AMPLITUDE_O};
            default: PRDATA_O <= 32'h0000_0000;
         endcase
      end
   end

   // Configuration register with byte strobes; upper bits reserved
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         conf_reg <= {24'h000000, 4'h0, RST_LIM} | ({28'h0, RST_REG} << POS_REG);
      end else if (wr_en && PADDR_I == OFS_CHOP_CONF) begin
         if (PSTRB_I[0]) conf_reg[7:0] <= PWDATA_I[7:0];
         if (PSTRB_I[1]) conf_reg[15:8] <= PWDATA_I[15:8];
         if (PSTRB_I[2]) conf_reg[18:16] <= PWDATA_I[18:16];
      end
   end

   // Offset and gradient amplitudes
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ampl_reg <= {RST_GRAD, RST_OFS};
      end else if (wr_en && PADDR_I == OFS_CHOP_AMPL) begin
         if (PSTRB_I[0]) ampl_reg[7:0] <= PWDATA_I[7:0];
         if (PSTRB_I[1]) ampl_reg[15:8] <= PWDATA_I[15:8];
      end
   end

   // Two-stage synchronisers for measurement inputs from outside logic
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         meas_s1_reg <= 8'h00;
         meas_s2_reg <= 8'h00;
         vel_s1_reg <= 8'h00;
         vel_s2_reg <= 8'h00;
         mv_s1_reg <= 1'b0;
         mv_s2_reg <= 1'b0;
         mv_d_reg <= 1'b0;
      end else begin
         meas_s1_reg <= CURRENT_MEAS_I;
         meas_s2_reg <= meas_s1_reg;
         vel_s1_reg <= VELOCITY_I;
         vel_s2_reg <= vel_s1_reg;
         mv_s1_reg <= CURRENT_MEAS_VALID_I;
         mv_s2_reg <= mv_s1_reg;
         mv_d_reg <= mv_s2_reg;
      end
   end

   // Regulator target is the amplitude last commanded, taken at each switching event
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         target_reg <= 8'h00;
      end else if (cif.switch_event) begin
         target_reg <= PWM_AMPLITUDE_O;
      end
   end

   amp_tuner u_tuner (
      .clk_i(CORE_CLK_I),
      .rst_i(RST_I),
      .step_i(mv_s2_reg && !mv_d_reg),
      .autoscale_i(autoscale),
      .autograd_i(autograd),
      .freeze_i(curmode),
      .gain_i(conf_reg[POS_REG +: 4]),
      .ofs_i(ampl_reg[POS_OFS +: 8]),
      .grad_i(ampl_reg[POS_GRAD +: 8]),
      .meas_i(meas_s2_reg),
      .target_i(target_reg),
      .scale_auto_o(scale_auto),
      .ofs_auto_o(ofs_auto),
      .grad_auto_o(grad_auto)
   );

   chop_timer u_timer (
      .clk_i(CORE_CLK_I),
      .rst_i(RST_I),
      .ctl(cif.gen)
   );

   // amplitude = offset + gradient * velocity, plus regulator in auto mode
   always_comb begin
      grad_use = (autoscale && autograd) ? grad_auto : ampl_reg[POS_GRAD +: 8];
      vel_prod = grad_use * vel_s2_reg;
      if (autoscale) begin
         amp_next = {2'b00, ofs_auto} + {2'b00, vel_prod[15:8]} + {scale_auto[8], scale_auto};
      end else begin
         amp_next = {2'b00, ampl_reg[POS_OFS +: 8]} + {2'b00, vel_prod[15:8]};
      end
      if (amp_next[9]) amp_sat = 8'h00;
      else if (amp_next[8]) amp_sat = 8'hff;
      else amp_sat = amp_next[7:0];
      limit8 = {lim, 4'hf};
   end

   // limit applies from the current-mode to quiet switch until lifted by a cycle
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         prev_curmode_reg <= 1'b0;
         limit_active_reg <= 1'b0;
      end else begin
         prev_curmode_reg <= curmode;
         if (prev_curmode_reg && !curmode) limit_active_reg <= 1'b1;
         else if (curmode || (cif.cycle_strobe && amp_sat <= limit8)) limit_active_reg <= 1'b0;
      end
   end

   // Amplitude updates once per chopper cycle; held at zero while disabled
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         PWM_AMPLITUDE_O <= 8'h00;
      end else if (!cif.chop_en) begin
         PWM_AMPLITUDE_O <= 8'h00;
      end else if (cif.cycle_strobe) begin
         PWM_AMPLITUDE_O <= (limit_active_reg && amp_sat > limit8) ? limit8 : amp_sat;
      end
   end

   // standstill behaviour, only while standstill is flagged
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         STANDSTILL_OPTION_MODE_O <= 1'b0;
         LS_SHORT_O <= 1'b0;
         HS_SHORT_O <= 1'b0;
      end else begin
         STANDSTILL_OPTION_MODE_O <= standstill_in && standstill == SS_STANDSTILL_OPTION;
         LS_SHORT_O <= standstill_in && standstill == SS_SHORT_LS;
         HS_SHORT_O <= standstill_in && standstill == SS_SHORT_HS;
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         CYCLE_STROBE_O <= 1'b0;
         BLANKING_O <= 1'b0;
      end else begin
         CYCLE_STROBE_O <= cif.cycle_strobe;
         BLANKING_O <= cif.blanking;
      end
   end
endmodule : quiet_chopper_cfg

// [dv/quiet_chopper_cfg_chk.sv]
`timescale 1ns/1ps
module quiet_chopper_cfg_chk
   import chop_cfg_pkg::*;
(
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   input wire logic [7:0] PWM_AMPLITUDE_O,
   input wire logic STANDSTILL_OPTION_MODE_O,
   input wire logic LS_SHORT_O,
   input wire logic HS_SHORT_O,
   input wire logic CYCLE_STROBE_O,
   input wire logic BLANKING_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   // Zero wait states, so a setup cycle is always answered next cycle
   property p_ready_next; PSEL_I && !PENABLE_I |=> PREADY_O; endproperty
   a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
   property p_ready_pulse; PREADY_O |=> !PREADY_O; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
   property p_err_ready; PSLVERR_O |-> PREADY_O && PSEL_I && PENABLE_I; endproperty
   a_err_ready: assert property (p_err_ready) else $error("error outside access");
   property p_unmapped; PSEL_I && !PENABLE_I && PADDR_I > 8'h0c |=> PSLVERR_O; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
   property p_unmapped_rd; PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I > 8'h0c |=> PRDATA_O == 32'h0; endproperty
   a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
   property p_strobe; CYCLE_STROBE_O |=> !CYCLE_STROBE_O; endproperty
   a_strobe: assert property (p_strobe) else $error("strobe longer than one cycle");
   property p_ss_excl; $onehot0({STANDSTILL_OPTION_MODE_O, LS_SHORT_O, HS_SHORT_O}); endproperty
   a_ss_excl: assert property (p_ss_excl) else $error("standstill modes overlap");
   // Shortest blank time is 16 cycles, so 8 is a safe lower bound
   property p_blank; $rose(BLANKING_O) |=> BLANKING_O [*8]; endproperty
   a_blank: assert property (p_blank) else $error("blanking too short");
   property p_amp; $changed(PWM_AMPLITUDE_O) && PWM_AMPLITUDE_O != 8'h00 |-> CYCLE_STROBE_O || $past(CYCLE_STROBE_O);
   endproperty
   a_amp: assert property (p_amp) else $error("amplitude changed off strobe");
   c_err: cover property (PSLVERR_O);
   c_strobe: cover property (CYCLE_STROBE_O);
   c_blank: cover property ($fell(BLANKING_O));
endmodule : quiet_chopper_cfg_chk
bind quiet_chopper_cfg quiet_chopper_cfg_chk u_chk (.CORE_CLK_I, .RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
   .PRDATA_O, .PREADY_O, .PSLVERR_O, .PWM_AMPLITUDE_O, .STANDSTILL_OPTION_MODE_O, .LS_SHORT_O, .HS_SHORT_O,
   .CYCLE_STROBE_O, .BLANKING_O);

// [dv/apb_host_model.sv]
`timescale 1ns/1ps
module apb_host_model (
   input wire logic clk_i,
   input wire logic pready_i,
   input wire logic [31:0] prdata_i,
   input wire logic pslverr_i,
   output logic psel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [7:0] paddr_o,
   output logic [31:0] pwdata_o,
   output logic [3:0] pstrb_o
);
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 8'h00;
      pwdata_o = 32'h0;
      pstrb_o = 4'h0;
   end
   // One transfer; waits an edge first so releases and setups never share a time step
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] q, output logic e);
      int n;
      @(posedge clk_i);
      psel_o <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      pstrb_o <= s;
      @(posedge clk_i);
      penable_o <= 1'b1;
      n = 0;
      @(posedge clk_i);
      // Hold the request until ready is seen; the bench watchdog ends a hang
      while (pready_i !== 1'b1) begin
         n++;
         @(posedge clk_i);
      end
      q = prdata_i;
      e = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      pwdata_o <= ~d;
   endtask : xfer
endmodule : apb_host_model

// [dv/tb_quiet_chopper_pwm_config.sv]
`timescale 1ns/1ps
module tb_quiet_chopper_pwm_config
   import chop_cfg_pkg::*;
;
   logic clk, rst, psel, pen, pwr, rdy, err, mvalid, fw, ls, hs, stb, blank;
   logic [7:0] paddr, meas, vel, amp;
   logic [31:0] pwd, prd, q, s0, s1;
   logic [3:0] pstrb;
   logic e;
   int fail_count = 0;
   int checks_done = 0;
   int n;
   logic [9:0] half_tab [4] = '{FREQ_DIV0, FREQ_DIV1, FREQ_DIV2, FREQ_DIV3};
   logic [5:0] blank_tab [4] = '{BLANK_0, BLANK_1, BLANK_2, BLANK_3};
   quiet_chopper_cfg DUT (.CORE_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwd), .PSTRB_I(pstrb), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err),
      .CURRENT_MEAS_VALID_I(mvalid), .CURRENT_MEAS_I(meas), .VELOCITY_I(vel), .PWM_AMPLITUDE_O(amp),
      .STANDSTILL_OPTION_MODE_O(fw), .LS_SHORT_O(ls), .HS_SHORT_O(hs), .CYCLE_STROBE_O(stb), .BLANKING_O(blank));
   apb_host_model host (.clk_i(clk), .pready_i(rdy), .prdata_i(prd), .pslverr_i(err), .psel_o(psel),
      .penable_o(pen), .pwrite_o(pwr), .paddr_o(paddr), .pwdata_o(pwd), .pstrb_o(pstrb));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      host.xfer(1'b1, a, d, s, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      host.xfer(1'b0, a, 32'h0, 4'h0, q, e);
   endtask : rd
   // Two strobes, so the amplitude seen was computed from settings already written
   task automatic wait_cycle();
      for (int k = 0; k < 2; k++) begin
         @(negedge clk);
         while (stb !== 1'b1) @(negedge clk);
      end
   endtask : wait_cycle
   // One rising edge on the measurement valid line gives one regulator update
   task automatic meas_pulse();
      @(posedge clk);
      mvalid <= 1'b1;
      repeat (8) @(posedge clk);
      mvalid <= 1'b0;
      repeat (8) @(posedge clk);
   endtask : meas_pulse
   // Reset value of the configuration word, full write mask and byte strobes of both writable words
   task automatic t_fields();
      rd(OFS_CHOP_CONF);
      check(q, 32'h0000_010c);
      wr(OFS_CHOP_CONF, 32'hffff_ffff, 4'hf);
      rd(OFS_CHOP_CONF);
      check(q, 32'h0007_ffff);
      wr(OFS_CHOP_CONF, 32'h0000_0000, 4'h1);
      rd(OFS_CHOP_CONF);
      check(q, 32'h0007_ff00);
      wr(OFS_CHOP_AMPL, 32'hffff_a55a, 4'hf);
      rd(OFS_CHOP_AMPL);
      check(q, 32'h0000_a55a);
      wr(OFS_CHOP_AMPL, 32'h0000_ff00, 4'h2);
      rd(OFS_CHOP_AMPL);
      check(q, 32'h0000_ff5a);
   endtask : t_fields
   // Unmapped place refuses and leaves the map alone
   task automatic t_unmapped();
      wr(8'h10, 32'hffff_ffff, 4'hf);
      check({31'h0, e}, 32'h1);
      rd(8'h10);
      check(q, 32'h0);
      rd(OFS_CHOP_AMPL);
      check(q, 32'h0000_ff5a);
   endtask : t_unmapped
   // Regulator result frozen while current mode runs, moves once it stops, and status is read-only
   task automatic t_frozen();
      // Full gain, so any update that slipped through the freeze would show
      wr(OFS_CHOP_CONF, 32'h0003_0f10, 4'hf);
      rd(OFS_CHOP_STAT);
      s0 = q;
      repeat (4) meas_pulse();
      rd(OFS_CHOP_STAT);
      s1 = q;
      check(s1 & 32'h01ff_ffff, s0 & 32'h01ff_ffff);
      wr(OFS_CHOP_STAT, 32'hffff_ffff, 4'hf);
      rd(OFS_CHOP_STAT);
      check(q & 32'h01ff_ffff, s1 & 32'h01ff_ffff);
      // Current mode off: scale moves, gradient readback keeps the user value
      wr(OFS_CHOP_CONF, 32'h0001_0f10, 4'hf);
      meas_pulse();
      rd(OFS_CHOP_STAT);
      check({31'h0, q[24:16] != s1[24:16]}, 32'h1);
      check({24'h0, q[15:8]}, 32'h0000_00ff);
      // Gradient tuning on: measurement sits above the target, so it leaves the user value
      wr(OFS_CHOP_CONF, 32'h0001_0f30, 4'hf);
      meas_pulse();
      rd(OFS_CHOP_STAT);
      check({31'h0, q[15:8] != 8'hff}, 32'h1);
   endtask : t_frozen
   // Each standstill option other than normal shown on its own output, normal on none
   task automatic t_standstill();
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CHOP_CONF, 32'h0005_0000 | (32'(i) << POS_STANDSTILL), 4'hf);
         repeat (4) @(posedge clk);
         @(negedge clk);
         check({29'h0, fw, ls, hs}, {29'h0, i == 1, i == 2, i == 3});
      end
      // Option set but standstill flag clear: normal drive
      wr(OFS_CHOP_CONF, 32'h0001_3000, 4'hf);
      repeat (4) @(posedge clk);
      @(negedge clk);
      check({29'h0, fw, ls, hs}, 32'h0);
   endtask : t_standstill
   // Forward amplitude is offset plus gradient times velocity over 256, capped after current mode
   task automatic t_amplitude();
      wr(OFS_CHOP_AMPL, 32'h0000_ff5a, 4'h3);
      wr(OFS_CHOP_CONF, 32'h0003_0003, 4'hf);
      wr(OFS_CHOP_CONF, 32'h0001_0003, 4'hf);
      wait_cycle();
      // Limit field 3 gives an eight-bit cap of 8'h3f
      check({24'h0, amp}, 32'h0000_003f);
      rd(OFS_CHOP_MEAS);
      check(q, 32'h0000_803f);
      wr(OFS_CHOP_CONF, 32'h0001_000f, 4'hf);
      wait_cycle();
      // 8'h5a plus (8'hff * 8'h20) / 256 gives 8'h79, under the raised cap
      check({24'h0, amp}, 32'h0000_0079);
      rd(OFS_CHOP_MEAS);
      check(q, 32'h0000_0079);
      wr(OFS_CHOP_CONF, 32'h0000_000f, 4'hf);
      repeat (2) @(posedge clk);
      @(negedge clk);
      check({24'h0, amp}, 32'h0);
   endtask : t_amplitude
   // Half period and blank length for each frequency and blank setting
   task automatic t_timing();
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CHOP_CONF, 32'h0001_0000 | (32'(i) << POS_FREQ) | (32'(i) << POS_BLANK), 4'hf);
         for (int k = 0; k < 2; k++) begin
            @(negedge clk);
            while (stb !== 1'b1) @(negedge clk);
         end
         n = 0;
         @(negedge clk);
         while (stb !== 1'b1 && n < 2000) begin
            n++;
            @(negedge clk);
         end
         check(32'(n + 1), {22'h0, half_tab[i]});
         while (blank !== 1'b1) @(negedge clk);
         n = 0;
         while (blank === 1'b1 && n < 200) begin
            n++;
            @(negedge clk);
         end
         check(32'(n), {26'h0, blank_tab[i]});
      end
   endtask : t_timing
   initial begin
      rst = 1'b1;
      mvalid = 1'b0;
      meas = 8'hf0;
      vel = 8'h20;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_fields();
      t_unmapped();
      t_frozen();
      t_standstill();
      t_timing();
      t_amplitude();
      finish_test();
   end
   initial begin
      #200000;
      fail_count++;
      finish_test();
   end
endmodule : tb_quiet_chopper_pwm_config
